// >>> logic/pll_clock_consts.vh
// constants for the clock mode generator: register address, fields, reset values
`ifndef PLL_CLOCK_CONSTS_VH
`define PLL_CLOCK_CONSTS_VH
`define CMC_ADDR 16'h0058
`define CMC_MUL_HI 15
`define CMC_MUL_LO 12
`define CMC_HALF_BIT 11
`define CMC_CNT_HI 10
`define CMC_CNT_LO 3
`define CMC_PLLON_BIT 2
`define CMC_MULMODE_BIT 1
`define CMC_STATUS_BIT 0
`define CMC_RST_000 16'h0000
`define CMC_RST_001 16'h9007
`define CMC_RST_010 16'h4007
`define CMC_RST_100 16'h1007
`define CMC_RST_110 16'hF007
`define CMC_RST_111 16'h0000
`define CMC_RST_101 16'hF000
`define CMC_RST_011 16'h0000
`define CMC_MUL_QUARTER 4'hF
`define LOCK_REF_PER_STEP 5'h10
`define PIN_SEL_OSC_OFF 3'h0
`endif

// >>> logic/pll_clock_mode_generator.v
// clock mode generator: divider and digital multiplier with lock timer and mode register
// Summary of operation
// - multiply mode: device clock is reference times one of 31 ratios
// - divider mode: device clock is reference divided by 2 or 4
// - in divider mode the multiplier can be fully switched off
// - programmable lock timer delays changeover to multiplied clock
// - multiplier acquires, then tracks; only after that is its clock used
// - 16-bit clock mode register at data address 0058h, read and write
// - reset value from pins: 001,010,100,110 give multiply modes, oscillator on
// - reset value from pins: 000,111,101 give divider modes; 011 also loads 0000h, divide by 2
// - mode pins are sampled while reset is held low
// - after reset, software writes reconfigure the clock mode
// - oscillator enable follows pins always; later pin changes touch nothing else
`timescale 1ns/1ps
`include "pll_clock_consts.vh"
module pll_clock_mode_generator #(
    parameter PER_W = 16
) (
    input wire mclk,
    input wire rst_n,
    input wire reference_clock_input,
    input wire mode_select_pin_a,
    input wire mode_select_pin_b,
    input wire mode_select_pin_c,
    input wire [15:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rdata,
    output reg device_clock,
    output reg osc_enable,
    output reg pll_power_en
);
    localparam ST_OFF = 2'b00;
    localparam ST_MEASURE = 2'b01;
    localparam ST_COUNT = 2'b10;
    localparam ST_LOCKED = 2'b11;
    localparam ACC_W = PER_W + 4;

    // pin synchronisers carry no reset so pins are sampled while reset is low
    reg [2:0] ref_sync_reg;
    reg [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
    reg ref_stable_reg;
    reg [2:0] pin_stable_reg;
    always @(posedge mclk) begin
        ref_sync_reg <= {ref_sync_reg[1:0], reference_clock_input};
        pin_s1_reg <= {mode_select_pin_a, mode_select_pin_b, mode_select_pin_c};
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
    end

    // a change counts only once the second and third stages agree
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_stable_reg <= 1'b0;
        end else if (ref_sync_reg[1] == ref_sync_reg[2]) begin
            ref_stable_reg <= ref_sync_reg[2];
        end
    end
    always @(posedge mclk) begin
        if (pin_s2_reg == pin_s3_reg) begin
            pin_stable_reg <= pin_s3_reg;
        end
    end
    wire ref_rise = (ref_sync_reg[1] == ref_sync_reg[2]) & ref_sync_reg[2] & ~ref_stable_reg;

    // reset value lookup from the pin pattern
    reg [15:0] pin_value;
    always @* begin
        case (pin_stable_reg)
            3'b001: pin_value = `CMC_RST_001;
            3'b010: pin_value = `CMC_RST_010;
            3'b100: pin_value = `CMC_RST_100;
            3'b110: pin_value = `CMC_RST_110;
            3'b000: pin_value = `CMC_RST_000;
            3'b111: pin_value = `CMC_RST_111;
            3'b101: pin_value = `CMC_RST_101;
            default: pin_value = `CMC_RST_011;
        endcase
    end

    // mode register; status bit is hardware owned
    reg init_done_reg;
    reg [15:1] mode_reg;
    reg [1:0] state_reg;
    reg use_pll_reg;
    wire hit = (addr == `CMC_ADDR);
    wire wr_hit = wr_en & hit;
    wire [3:0] mul = mode_reg[`CMC_MUL_HI:`CMC_MUL_LO];
    wire mul_mode = mode_reg[`CMC_MULMODE_BIT];
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            init_done_reg <= 1'b0;
            mode_reg <= 15'h0000;
        end else if (!init_done_reg) begin
            // first edge after release loads the value caught during reset
            init_done_reg <= 1'b1;
            mode_reg <= pin_value[15:1];
        end else if (wr_hit) begin
            mode_reg <= wdata[15:1];
        end
    end

    // register read port, unmapped addresses read zero
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (rd_en & hit) begin
            rdata <= {mode_reg, use_pll_reg};
        end else begin
            rdata <= 16'h0000;
        end
    end

    // oscillator enable tracks the pins regardless of reset or the register
    always @(posedge mclk) begin
        osc_enable <= (pin_stable_reg != `PIN_SEL_OSC_OFF);
    end

    // multiplier runs in multiply mode, or in divider mode only if left on
    wire pll_run = init_done_reg & (mul_mode | mode_reg[`CMC_PLLON_BIT]);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pll_power_en <= 1'b0;
        end else begin
            pll_power_en <= pll_run;
        end
    end

    // ratio num/den; den is a shift of 0,1,2
    reg [3:0] num;
    reg [1:0] den_sh;
    always @* begin
        num = 4'h1;
        den_sh = 2'h0;
        if (!mode_reg[`CMC_HALF_BIT]) begin
            num = (mul == `CMC_MUL_QUARTER) ? 4'h1 : mul + 4'h1;
        end else if (!mul[0]) begin
            num = mul + 4'h1;
            den_sh = 2'h1;
        end else begin
            num = mul;
            den_sh = 2'h2;
        end
    end

    // reference period in mclk cycles, measured between rising edges
    reg [PER_W-1:0] per_cnt_reg, period_reg;
    reg [1:0] edges_reg;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            per_cnt_reg <= {PER_W{1'b0}};
            period_reg <= {PER_W{1'b0}};
            edges_reg <= 2'h0;
        end else if (!pll_run) begin
            per_cnt_reg <= {PER_W{1'b0}};
            edges_reg <= 2'h0;
        end else if (ref_rise) begin
            per_cnt_reg <= {PER_W{1'b0}};
            period_reg <= per_cnt_reg + {{(PER_W-1){1'b0}}, 1'b1};
            if (edges_reg != 2'h3) begin
                edges_reg <= edges_reg + 2'h1;
            end
        end else if (per_cnt_reg != {PER_W{1'b1}}) begin
            per_cnt_reg <= per_cnt_reg + {{(PER_W-1){1'b0}}, 1'b1};
        end
    end

    // phase accumulator: toggles every period*den/(2*num) cycles
    // limitation: output cannot exceed mclk/2, so the reference must be slow
    reg [ACC_W-1:0] acc_reg;
    reg pll_clk_reg;
    wire [ACC_W-1:0] target = {4'h0, period_reg} << den_sh;
    wire [ACC_W-1:0] acc_sum = acc_reg + {{(ACC_W-5){1'b0}}, num, 1'b0};
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= {ACC_W{1'b0}};
            pll_clk_reg <= 1'b0;
        end else if (!pll_run || edges_reg < 2'h2) begin
            acc_reg <= {ACC_W{1'b0}};
            pll_clk_reg <= 1'b0;
        end else if (acc_sum >= target) begin
            acc_reg <= acc_sum - target;
            pll_clk_reg <= ~pll_clk_reg;
        end else begin
            acc_reg <= acc_sum;
        end
    end

    // divider: toggle per reference edge, or every second for divide by 4
    reg div_clk_reg;
    reg div_ph_reg;
    wire div4 = (mul == `CMC_MUL_QUARTER);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            div_clk_reg <= 1'b0;
            div_ph_reg <= 1'b0;
        end else if (ref_rise) begin
            div_ph_reg <= ~div_ph_reg;
            if (!div4 || div_ph_reg) begin
                div_clk_reg <= ~div_clk_reg;
            end
        end
    end

    // lock sequencer: acquire period, then wait count*16 reference cycles
    reg [12:0] lock_cnt_reg;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_OFF;
            lock_cnt_reg <= 13'h0000;
        end else if (!init_done_reg || wr_hit || !mul_mode) begin
            // any write to the mode register restarts acquisition, but a selected multiplier drives the new ratio to the output until the switch
            state_reg <= ST_OFF;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    state_reg <= ST_MEASURE;
                end
                ST_MEASURE: begin
                    if (edges_reg == 2'h3) begin
                        lock_cnt_reg <= {5'h00, mode_reg[`CMC_CNT_HI:`CMC_CNT_LO]}
                                        * {8'h00, `LOCK_REF_PER_STEP};
                        state_reg <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (lock_cnt_reg == 13'h0000) begin
                        state_reg <= ST_LOCKED;
                    end else if (ref_rise) begin
                        lock_cnt_reg <= lock_cnt_reg - 13'h0001;
                    end
                end
                ST_LOCKED: begin
                    state_reg <= ST_LOCKED;
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

    // source select changes only when output and both sources are low
    // a stopping multiplier is forced low at once, so its last high can be cut short before the switch
    wire want_pll = (state_reg == ST_LOCKED);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            use_pll_reg <= 1'b0;
        end else if (want_pll != use_pll_reg && !device_clock && !pll_clk_reg
                     && !div_clk_reg) begin
            use_pll_reg <= want_pll;
        end
    end

    // device clock output from a flop
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            device_clock <= 1'b0;
        end else if (!init_done_reg) begin
            device_clock <= 1'b0;
        end else begin
            device_clock <= use_pll_reg ? pll_clk_reg : div_clk_reg;
        end
    end
endmodule // pll_clock_mode_generator

// >>> test/ref_clock_source.sv
// reference source model: crystal-style clock feeding the reference pin
`timescale 1ns/1ps
module ref_clock_source #(
    parameter HALF_NS = 200
) (
    input wire run,
    output reg clk_out
);
    initial clk_out = 1'b0;
    // a stopped oscillator rests low instead of holding a stale phase
    always begin
        #(HALF_NS) clk_out = run ? ~clk_out : 1'b0;
    end
endmodule // ref_clock_source

// >>> test/pll_clock_checker.sv
// checker: port-level assertions for the clock mode generator
`timescale 1ns/1ps
module pll_clock_checker (
    input wire mclk,
    input wire rst_n,
    input wire mode_select_pin_a,
    input wire mode_select_pin_b,
    input wire mode_select_pin_c,
    input wire [15:0] addr,
    input wire [15:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [15:0] rdata,
    input wire device_clock,
    input wire osc_enable,
    input wire pll_power_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire [2:0] pins = {mode_select_pin_a, mode_select_pin_b, mode_select_pin_c};
    wire wr_hit = wr_en && addr == 16'h0058;
    wire rd_hit = rd_en && addr == 16'h0058;
    reg wrote_reg;
    reg [15:0] last_w_reg;
    // last software write, so readback can be tied to it
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrote_reg <= 1'b0;
            last_w_reg <= 16'h0000;
        end else if (wr_hit) begin
            wrote_reg <= 1'b1;
            last_w_reg <= wdata;
        end
    end
    a_rdata_idle_zero: assert property (!$past(rd_hit) |-> rdata == 16'h0000)
        else $error("rdata not zero without a read");
    a_unmapped_read: assert property (rd_en && addr != 16'h0058 |=> rdata == 16'h0000)
        else $error("unmapped read returned data");
    a_write_readback: assert property (wrote_reg && rd_hit |=> rdata[15:1] == last_w_reg[15:1])
        else $error("readback differs from last write");
    a_osc_follows_pins: assert property ($stable(pins)[*5] |-> osc_enable == (pins != 3'h0))
        else $error("oscillator enable does not follow pins");
    a_pll_off_div: assert property (wr_hit && !wdata[1] && !wdata[2] |-> ##[1:4] !pll_power_en)
        else $error("multiplier still powered in divider mode");
    a_pll_on_mult: assert property (wr_hit && wdata[1] |-> ##[1:4] pll_power_en)
        else $error("multiplier not powered in multiply mode");
    a_lock_holdoff: assert property (wr_hit ##[1:6] rd_hit |=> !rdata[0])
        else $error("lock status set right after a write");
    a_no_short_pulse: assert property ($rose(device_clock) |=> device_clock)
        else $error("device clock high pulse too short");
endmodule // pll_clock_checker
bind pll_clock_mode_generator pll_clock_checker chk (.mclk(mclk), .rst_n(rst_n),
    .mode_select_pin_a(mode_select_pin_a), .mode_select_pin_b(mode_select_pin_b),
    .mode_select_pin_c(mode_select_pin_c), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .device_clock(device_clock), .osc_enable(osc_enable),
    .pll_power_en(pll_power_en));

// >>> test/testbench.sv
// testbench: reset table, register access, pin changes and clock periods
`timescale 1ns/1ps
module testbench;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg [2:0] pins = 3'h0;
    reg [15:0] addr = 16'h0000;
    reg [15:0] wdata = 16'h0000;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    wire ref_clk;
    wire [15:0] rdata;
    wire device_clock;
    wire osc_enable;
    wire pll_power_en;
    integer err_count = 0;
    integer num_checks = 0;
    reg [15:0] rv;
    // reset values indexed by pin pattern a,b,c
    localparam logic [15:0] RST_TAB [0:7] = '{16'h0000, 16'h9007, 16'h4007, 16'h0000,
        16'h1007, 16'hF000, 16'hF007, 16'h0000};
    always #5 mclk = ~mclk;
    ref_clock_source #(.HALF_NS(200)) src (.run(osc_enable), .clk_out(ref_clk));
    pll_clock_mode_generator dut (.mclk(mclk), .rst_n(rst_n),
        .reference_clock_input(ref_clk), .mode_select_pin_a(pins[2]),
        .mode_select_pin_b(pins[1]), .mode_select_pin_c(pins[0]), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .device_clock(device_clock), .osc_enable(osc_enable), .pll_power_en(pll_power_en));
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask
    task complete_run;
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input [15:0] a, input [15:0] d);
        @(posedge mclk);
        #1 addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge mclk);
        #1 wr_en = 1'b0;
    endtask
    task rd(input [15:0] a, output [15:0] d);
        @(posedge mclk);
        #1 addr = a;
        rd_en = 1'b1;
        @(posedge mclk);
        #1 rd_en = 1'b0;
        d = rdata;
    endtask
    task reset_with(input [2:0] p);
        pins = p;
        rst_n = 1'b0;
        repeat (8) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge mclk);
    endtask
    // align on a rise, then count mclk cycles from rise to rise (high part plus low part)
    // looks 1 ns after each edge so the flop output has settled
    task period_is(input integer e);
        integer n;
        integer k;
        for (k = 0; k < 3; k++) begin
            n = 0;
            while (device_clock !== 1'b0 && n < 400) begin
                @(posedge mclk);
                #1;
                n++;
            end
            while (device_clock !== 1'b1 && n < 400) begin
                @(posedge mclk);
                #1;
                n++;
            end
        end
        check("clock period", (n >= e - 1 && n <= e + 1) ? e : n, e);
    endtask
    task pin_table;
        integer i;
        for (i = 0; i < 8; i++) begin
            reset_with(i[2:0]);
            rd(16'h0058, rv);
            check("reset value", rv & 16'hFFFE, RST_TAB[i] & 16'hFFFE);
            check("osc enable", {15'h0, osc_enable}, {15'h0, i != 0});
            check("pll power", {15'h0, pll_power_en}, {15'h0, RST_TAB[i][1]});
        end
    endtask
    task pin_change_after_reset;
        reset_with(3'h1);
        #1 pins = 3'h0;
        repeat (8) @(posedge mclk);
        #1 check("osc after pin change", {15'h0, osc_enable}, 16'h0000);
        rd(16'h0058, rv);
        check("mode after pin change", rv & 16'hFFFE, 16'h9006);
        pins = 3'h1;
    endtask
    task reg_access;
        wr(16'h0058, 16'h5A5A);
        rd(16'h0058, rv);
        check("readback", rv & 16'hFFFE, 16'h5A5A);
        wr(16'h0059, 16'hFFFF);
        rd(16'h0058, rv);
        check("after unmapped write", rv & 16'hFFFE, 16'h5A5A);
        rd(16'h0059, rv);
        check("unmapped read", rv, 16'h0000);
    endtask
    // reference period 400 ns is 40 mclk cycles
    task clock_modes;
        integer n;
        wr(16'h0058, 16'h0000);
        period_is(80);
        check("pll off div2", {15'h0, pll_power_en}, 16'h0000);
        wr(16'h0058, 16'hF000);
        period_is(160);
        wr(16'h0058, 16'h100E);
        rv = 16'h0000;
        for (n = 0; n < 1000 && rv[0] !== 1'b1; n++) rd(16'h0058, rv);
        check("lock status", {15'h0, rv[0]}, 16'h0001);
        // lock count 1 is 16 reference periods of 40 cycles, two cycles per poll
        check("lock hold-off", {15'h0, n >= 320}, 16'h0001);
        check("pll power mult", {15'h0, pll_power_en}, 16'h0001);
        period_is(20);
    endtask
    initial begin
        #500000;
        err_count++;
        complete_run();
    end
    initial begin
        pin_table();
        pin_change_after_reset();
        reg_access();
        clock_modes();
        complete_run();
    end
endmodule // testbench
